// >>> acr_pkg.sv
// constants and types shared by the converter register control block
package acr_pkg;
  localparam int unsigned RES_W      = 10;
  localparam int unsigned NUM_INPUTS = 5;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;

  localparam logic [7:0] OFF_CSR      = 8'h34;
  localparam logic [7:0] OFF_RES_HI   = 8'h35;
  localparam logic [7:0] OFF_RES_LO   = 8'h36;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h37;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h38;

  localparam int unsigned BIT_EOC   = 7;
  localparam int unsigned BIT_SPEED = 6;
  localparam int unsigned BIT_ON    = 5;
  localparam int unsigned BIT_SLOW  = 3;
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_OVR   = 1;

  localparam logic [7:0] RST_REG = 8'h00;

  // converter clock ticks per phase
  localparam int unsigned SAMPLE_TICKS = 4;
  localparam int unsigned SETTLE_TICKS = 5;

  typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4} acr_div_t;
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_HOLD} acr_sar_t;
endpackage

// >>> acr_conv_if.sv
// link between register logic, converter clock divider and sequencer
`timescale 1ns/1ps
`default_nettype none
interface acr_conv_if #(parameter int unsigned RES_W = acr_pkg::RES_W);
  logic             enable;
  logic             restart;
  logic             comp;
  acr_pkg::acr_div_t div_sel;
  logic             tick;
  logic             done;
  logic             sample;
  logic [RES_W-1:0] code;
  logic [RES_W-1:0] result;
  modport ctl (output enable, restart, comp, div_sel, input tick, done, sample, code, result);
  modport div (input enable, restart, div_sel, output tick);
  modport sar (input enable, restart, comp, tick, output done, sample, code, result);
endinterface
`default_nettype wire

// >>> acr_clkdiv.sv
// converter clock enable derived from the cpu clock
`timescale 1ns/1ps
`default_nettype none
module acr_clkdiv (
  input wire logic i_clk,
  input wire logic i_rst_n,
  acr_conv_if.div  cv
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } acr_div_st_t;

  acr_div_st_t s_r;
  acr_div_st_t s_nxt;

  // phase counter restarts with each csr write that sets the on bit so the first tick is aligned
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!cv.enable || cv.restart) begin
      s_nxt.cnt = 2'h0;
    end else begin
      s_nxt.cnt = s_r.cnt + 2'h1;
      case (cv.div_sel)
        acr_pkg::DIV_1: s_nxt.tick = 1'b1;
        acr_pkg::DIV_2: s_nxt.tick = s_r.cnt[0];
        acr_pkg::DIV_4: s_nxt.tick = (s_r.cnt == 2'h3);
        default:        s_nxt.tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cv.tick = s_r.tick;

  AST_DIV1_EVERY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cv.enable && !cv.restart && cv.div_sel == acr_pkg::DIV_1) |=> cv.tick)
    else $error("full rate tick missing");
  AST_DIV4_GAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cv.tick && cv.div_sel == acr_pkg::DIV_4 && $stable(cv.div_sel)) |=> !cv.tick[*3])
    else $error("quarter rate ticks too close");
endmodule
`default_nettype wire

// >>> acr_sar.sv
// successive approximation sequencer: sample then hold, repeated while on
`timescale 1ns/1ps
`default_nettype none
module acr_sar #(
  parameter int unsigned RES_W        = acr_pkg::RES_W,
  parameter int unsigned SAMPLE_TICKS = acr_pkg::SAMPLE_TICKS,
  parameter int unsigned SETTLE_TICKS = acr_pkg::SETTLE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  acr_conv_if.sar  cv
);
  localparam int unsigned IW = $clog2(RES_W);

  // settle must cover three sync stages plus the agree step at full rate
  initial begin
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 256 || SETTLE_TICKS < 5 || SETTLE_TICKS > 256 || RES_W < 2)
      $error("acr_sar: unsupported parameters");
  end

  typedef struct packed {
    acr_pkg::acr_sar_t state;
    logic [7:0]        cnt;
    logic [IW-1:0]     idx;
    logic [RES_W-1:0]  code;
    logic [RES_W-1:0]  result;
    logic              done;
    logic              sample;
  } acr_sar_st_t;

  acr_sar_st_t s_r;
  acr_sar_st_t s_nxt;

  // restart wins over a tick so an aborted conversion never completes
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!cv.enable) begin
      s_nxt.state = acr_pkg::SAR_IDLE;
      s_nxt.sample = 1'b0;
      s_nxt.cnt = 8'h00;
    end else if (cv.restart || s_r.state == acr_pkg::SAR_IDLE) begin
      s_nxt.state = acr_pkg::SAR_SAMPLE;
      s_nxt.sample = 1'b1;
      s_nxt.cnt = 8'h00;
    end else if (cv.tick) begin
      case (s_r.state)
        acr_pkg::SAR_SAMPLE: begin
          if (s_r.cnt == 8'(SAMPLE_TICKS - 1)) begin
            s_nxt.state = acr_pkg::SAR_HOLD;
            s_nxt.sample = 1'b0;
            s_nxt.cnt = 8'h00;
            s_nxt.idx = IW'(RES_W - 1);
            s_nxt.code = {1'b1, {(RES_W-1){1'b0}}};
          end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
          end
        end
        acr_pkg::SAR_HOLD: begin
          if (s_r.cnt == 8'(SETTLE_TICKS - 1)) begin
            s_nxt.cnt = 8'h00;
            if (!cv.comp) begin
              s_nxt.code[s_r.idx] = 1'b0;
            end
            if (s_r.idx == '0) begin
              s_nxt.done = 1'b1;
              s_nxt.result = s_nxt.code;
              s_nxt.state = acr_pkg::SAR_SAMPLE;
              s_nxt.sample = 1'b1;
            end else begin
              s_nxt.idx = s_r.idx - IW'(1);
              s_nxt.code[s_r.idx - IW'(1)] = 1'b1;
            end
          end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
          end
        end
        default: s_nxt.state = acr_pkg::SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cv.done = s_r.done;
  assign cv.sample = s_r.sample;
  assign cv.code = s_r.code;
  assign cv.result = s_r.result;

  AST_DONE_RESAMPLES: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cv.done |-> cv.sample)
    else $error("no new sample after completion");
  AST_OFF_QUIET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cv.enable |=> (!cv.sample && !cv.done))
    else $error("converter active while off");
endmodule
`default_nettype wire

// >>> acr_top.sv
// register control of the 10-bit converter: csr, result bytes, interrupt
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module acr_top #(
  parameter int unsigned SAMPLE_TICKS = acr_pkg::SAMPLE_TICKS,
  parameter int unsigned SETTLE_TICKS = acr_pkg::SETTLE_TICKS
) (
  input  wire logic                             I_CLOCK,
  input  wire logic                             I_RST_N,
  input  wire logic [acr_pkg::ADDR_W-1:0]       I_ADDR,
  input  wire logic [acr_pkg::DATA_W-1:0]       I_WDATA,
  input  wire logic                             I_WRITE,
  input  wire logic                             I_READ,
  output logic      [acr_pkg::DATA_W-1:0]       O_RDATA,
  input  wire logic                             I_COMPARE,
  output logic      [acr_pkg::RES_W-1:0]        O_DAC_CODE,
  output logic                                  O_SAMPLE,
  output logic      [acr_pkg::NUM_INPUTS-1:0]   O_ANALOG_IN_EN,
  output logic                                  O_CONVERTER_ON,
  output logic                                  O_IRQ
);
  typedef struct packed {
    logic        speed;
    logic        conv_on;
    logic [2:0]  input_select;
    logic        slow;
    logic        eoc;
    logic [7:0]  res_hi;
    logic [1:0]  res_lo;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [7:0]  rdata;
    logic        restart;
    logic [4:0]  ain_en;
    logic [2:0]  sync;
    logic        comp;
  } acr_top_st_t;

  acr_top_st_t s_r;
  acr_top_st_t s_nxt;

  acr_conv_if #(.RES_W(acr_pkg::RES_W)) cv ();

  // one-hot input enable; codes above four select nothing
  function automatic logic [4:0] sel_decode(input logic [2:0] sel);
    logic [4:0] oh;
    oh = 5'h00;
    if (sel < 3'h5) begin
      oh[sel] = 1'b1;
    end
    return oh;
  endfunction

  // register read mux; reserved positions read zero
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input acr_top_st_t st);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      acr_pkg::OFF_CSR: begin
        d[acr_pkg::BIT_EOC] = st.eoc;
        d[acr_pkg::BIT_SPEED] = st.speed;
        d[acr_pkg::BIT_ON] = st.conv_on;
        d[2:0] = st.input_select;
      end
      acr_pkg::OFF_RES_HI: d = st.res_hi;
      acr_pkg::OFF_RES_LO: begin
        d[acr_pkg::BIT_SLOW] = st.slow;
        d[1:0] = st.res_lo;
      end
      acr_pkg::OFF_IRQ_STAT: d[1:0] = st.irq_stat;
      acr_pkg::OFF_IRQ_MASK: d[1:0] = st.irq_mask;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  logic wr_csr;
  logic rd_hi;

  assign wr_csr = I_WRITE && (I_ADDR == acr_pkg::OFF_CSR);
  assign rd_hi = I_READ && (I_ADDR == acr_pkg::OFF_RES_HI);

  // next state: bus writes and reads first, hardware sets last so sets win
  always_comb begin
    s_nxt = s_r;
    s_nxt.restart = 1'b0;
    s_nxt.rdata = 8'h00;

    // comparator from the analog side: three stages, take when last two agree
    s_nxt.sync = {s_r.sync[1:0], I_COMPARE};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.comp = s_r.sync[1];
    end

    if (I_WRITE) begin
      case (I_ADDR)
        acr_pkg::OFF_CSR: begin
          // done flag ignores its own written bit; a write with the on bit set clears it
          s_nxt.speed = I_WDATA[acr_pkg::BIT_SPEED];
          s_nxt.conv_on = I_WDATA[acr_pkg::BIT_ON];
          s_nxt.input_select = I_WDATA[2:0];
          if (I_WDATA[acr_pkg::BIT_ON]) begin
            s_nxt.restart = 1'b1;
            s_nxt.eoc = 1'b0;
          end
        end
        acr_pkg::OFF_RES_LO: s_nxt.slow = I_WDATA[acr_pkg::BIT_SLOW];
        acr_pkg::OFF_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~I_WDATA[1:0];
        acr_pkg::OFF_IRQ_MASK: s_nxt.irq_mask = I_WDATA[1:0];
        default: s_nxt.irq_mask = s_r.irq_mask;
      endcase
    end

    if (I_READ) begin
      s_nxt.rdata = reg_read(I_ADDR, s_r);
    end
    if (rd_hi) begin
      s_nxt.eoc = 1'b0;
    end

    // completion loads both bytes in one edge so a pair read stays coherent
    if (cv.done) begin
      s_nxt.res_hi = cv.result[9:2];
      s_nxt.res_lo = cv.result[1:0];
      s_nxt.eoc = 1'b1;
      s_nxt.irq_stat[acr_pkg::IRQ_DONE] = 1'b1;
      // previous result never fetched: flag the loss
      if (s_r.eoc && !rd_hi) begin
        s_nxt.irq_stat[acr_pkg::IRQ_OVR] = 1'b1;
      end
    end

    s_nxt.ain_en = sel_decode(s_nxt.input_select);
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // divider selection from slow and speed; slow dominates
  always_comb begin
    if (s_r.slow) begin
      cv.div_sel = acr_pkg::DIV_4;
    end else if (s_r.speed) begin
      cv.div_sel = acr_pkg::DIV_1;
    end else begin
      cv.div_sel = acr_pkg::DIV_2;
    end
  end

  assign cv.enable = s_r.conv_on;
  assign cv.restart = s_r.restart;
  assign cv.comp = s_r.comp;

  acr_clkdiv u_div (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .cv      (cv.div)
  );

  acr_sar #(
    .RES_W        (acr_pkg::RES_W),
    .SAMPLE_TICKS (SAMPLE_TICKS),
    .SETTLE_TICKS (SETTLE_TICKS)
  ) u_sar (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .cv      (cv.sar)
  );

  // outputs; irq is a level from registered status and mask
  assign O_RDATA = s_r.rdata;
  assign O_DAC_CODE = cv.code;
  assign O_SAMPLE = cv.sample;
  assign O_ANALOG_IN_EN = s_r.ain_en;
  assign O_CONVERTER_ON = s_r.conv_on;
  assign O_IRQ = |(s_r.irq_stat & s_r.irq_mask);

  AST_EOC_SET: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cv.done |=> s_r.eoc)
    else $error("done flag not set on completion");
  AST_EOC_CLR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (rd_hi && !cv.done) |=> !s_r.eoc)
    else $error("done flag not cleared by high read");
  AST_EOC_RO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (wr_csr && !I_WDATA[acr_pkg::BIT_ON] && !cv.done) |=> (s_r.eoc == $past(s_r.eoc)))
    else $error("done flag changed by write");
  AST_ON_BIT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    wr_csr |=> (O_CONVERTER_ON == $past(I_WDATA[acr_pkg::BIT_ON])))
    else $error("converter on bit not taken");
  AST_SEL_FOUR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (wr_csr && I_WDATA[2:0] == 3'h4) |=> (O_ANALOG_IN_EN == 5'h10))
    else $error("input four not selected");
  AST_ABORT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (wr_csr && I_WDATA[acr_pkg::BIT_ON] && !cv.done) |=> (!s_r.eoc && s_r.restart) ##1 O_SAMPLE)
    else $error("write while on did not restart");
  AST_RES_LOAD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cv.done |=> ({s_r.res_hi, s_r.res_lo} == $past(cv.result)))
    else $error("result bytes not loaded");
  AST_LO_ZERO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_READ && I_ADDR == acr_pkg::OFF_RES_LO) |=> (O_RDATA[7:4] == 4'h0 && !O_RDATA[2]))
    else $error("reserved low bits not zero");
  AST_RES_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !cv.done |=> ($stable(s_r.res_hi) && $stable(s_r.res_lo)))
    else $error("result changed between completions");
  AST_HI_READ: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    rd_hi |=> (O_RDATA == s_r.res_hi || $past(cv.done)))
    else $error("high byte read mismatch");

  COV_DONE: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N) cv.done);
  COV_PAIR_READ: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (s_r.eoc && I_READ && I_ADDR == acr_pkg::OFF_RES_LO) ##1 rd_hi);
  COV_ABORT: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (wr_csr && s_r.conv_on && !O_SAMPLE));
  COV_IRQ: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N) O_IRQ);
endmodule
`default_nettype wire

// >>> acr_top_tb.sv
// self-checking bench for the converter register control block
`timescale 1ns/1ps
`default_nettype none
module acr_top_tb;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] re;
  } acr_row_t;

  localparam int SETTLE = 8;
  localparam int CONV   = 4 + 10 * SETTLE;
  localparam int LIMIT  = 12000;

  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  logic       cmp;
  logic [9:0] dac;
  logic       smp;
  logic [4:0] ain_en;
  logic       conv_on;
  logic       irq;
  logic [9:0] target;
  logic [7:0] d;
  int         t;
  int         cyc;
  int         err_total;
  int         samples_checked;
  acr_row_t   rows [11];

  // settle stretched so the bench comparator flop plus the sync chain fit
  acr_top #(.SETTLE_TICKS(SETTLE)) acr_top_inst (
    .I_CLOCK        (clk),
    .I_RST_N        (rst_n),
    .I_ADDR         (addr),
    .I_WDATA        (wdata),
    .I_WRITE        (wr_s),
    .I_READ         (rd_s),
    .O_RDATA        (rdata),
    .I_COMPARE      (cmp),
    .O_DAC_CODE     (dac),
    .O_SAMPLE       (smp),
    .O_ANALOG_IN_EN (ain_en),
    .O_CONVERTER_ON (conv_on),
    .O_IRQ          (irq)
  );

  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // analog side: keep the trial bit while the input is at or above it
  always @(posedge clk) begin
    cmp <= (target >= dac);
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("BAD timeout expected %0d seen %0d", LIMIT, cyc);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe, taken at the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(name, {8'h00, v}, {8'h00, e});
  endtask

  // bounded poll of the done flag, returns the cycle it was seen
  task automatic poll_eoc(output int tm);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 400 && v[7] !== 1'b1; k++)
      rd(8'h34, v);
    tm = cyc;
    chk("eoc", {15'h0, v[7]}, 16'h1);
  endtask

  // one clock setting: result bytes, flag clear, completion spacing
  task automatic meas(input logic spd, input logic slw, input int dv, input logic [9:0] tv);
    int         t0;
    int         t1;
    logic [7:0] csr;
    logic [7:0] v;
    csr    = {1'b0, spd, 1'b1, 5'h01};
    target = tv;
    // stop first so no stale completion lands beside the restart
    wr(8'h34, 8'h00);
    wr(8'h36, {4'h0, slw, 3'h0});
    wr(8'h34, csr);
    chk("on", conv_on, 16'h1);
    chk("ain_en", ain_en, 16'h2);
    for (int k = 0; k < 8 && smp !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("sample", smp, 16'h1);
    poll_eoc(t0);
    rd_chk("res_lo", 8'h36, {4'h0, slw, 1'b0, tv[1:0]});
    rd_chk("res_hi", 8'h35, tv[9:2]);
    rd_chk("csr", 8'h34, csr);
    poll_eoc(t1);
    chk("period", 16'((t1 - t0) >= CONV * dv - 2 && (t1 - t0) <= CONV * dv + 2 * dv + 2), 16'h1);
    rd(8'h35, v);
    $display("test clock setting %0d done", dv);
  endtask

  initial begin
    rst_n           = 1'b0;
    addr            = 8'h00;
    wdata           = 8'h00;
    wr_s            = 1'b0;
    rd_s            = 1'b0;
    cmp             = 1'b0;
    target          = 10'h000;
    cyc             = 0;
    err_total       = 0;
    samples_checked = 0;
    // write, then read back; last row leaves the mask open
    rows = '{'{8'h34, 8'hc4, 8'h34, 8'h44}, '{8'h34, 8'h03, 8'h34, 8'h03},
             '{8'h34, 8'h42, 8'h34, 8'h42}, '{8'h34, 8'h01, 8'h34, 8'h01},
             '{8'h34, 8'h00, 8'h34, 8'h00}, '{8'h34, 8'h07, 8'h34, 8'h07},
             '{8'h36, 8'hff, 8'h36, 8'h08}, '{8'h36, 8'h00, 8'h36, 8'h00},
             '{8'h35, 8'hff, 8'h35, 8'h00}, '{8'h40, 8'hff, 8'h40, 8'h00},
             '{8'h38, 8'h03, 8'h38, 8'h03}};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 'h34; a <= 'h38; a++)
      rd_chk("reset", 8'(a), 8'h00);
    chk("on_rst", conv_on, 16'h0);
    $display("test reset done");

    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd_chk("table", rows[i].ra, rows[i].re);
      if (rows[i].ra == 8'h34)
        chk("ain_en", ain_en, rows[i].re[2:0] < 3'h5 ? 16'(5'h01 << rows[i].re[2:0]) : 16'h0);
    end
    $display("test table done");

    meas(1'b1, 1'b0, 1, 10'h2a7);
    meas(1'b0, 1'b0, 2, 10'h3ff);
    meas(1'b1, 1'b1, 4, 10'h000);
    meas(1'b0, 1'b1, 4, 10'h155);

    // writes closer than one conversion must keep restarting it
    // divider only changed while off, so no tick phase is cut short
    wr(8'h34, 8'h00);
    wr(8'h36, 8'h00);
    wr(8'h34, 8'h60);
    poll_eoc(t);
    wr(8'h34, 8'h60);
    wr(8'h37, 8'h03);
    rd_chk("abort", 8'h34, 8'h60);
    repeat (6) begin
      repeat (40) @(posedge clk);
      wr(8'h34, 8'h60);
    end
    rd_chk("abort", 8'h34, 8'h60);
    // sticky done still clear: no conversion finished between the writes
    rd_chk("abort_stat", 8'h37, 8'h00);
    poll_eoc(t);
    $display("test abort done");

    // sticky done event against the mask
    wr(8'h34, 8'h00);
    chk("off", conv_on, 16'h0);
    rd(8'h37, d);
    chk("irq_stat", {15'h0, d[0]}, 16'h1);
    chk("irq", irq, 16'h1);
    wr(8'h38, 8'h00);
    chk("irq", irq, 16'h0);
    wr(8'h38, 8'h01);
    chk("irq", irq, 16'h1);
    wr(8'h37, 8'h03);
    rd_chk("irq_stat", 8'h37, 8'h00);
    chk("irq", irq, 16'h0);
    $display("test interrupt done");

    // nothing runs while off
    rd(8'h35, d);
    repeat (400) @(posedge clk);
    rd_chk("off_csr", 8'h34, 8'h00);
    rd_chk("off_stat", 8'h37, 8'h00);
    chk("off_sample", smp, 16'h0);
    $display("test off done");

    // reset in mid-run clears results and settings
    wr(8'h36, 8'h08);
    wr(8'h34, 8'h25);
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("rerst", 8'h34, 8'h00);
    rd_chk("rerst", 8'h35, 8'h00);
    rd_chk("rerst", 8'h36, 8'h00);
    chk("rerst_on", conv_on, 16'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
